/* File: verilog/wm_params.svh */
// Timing constants, reset value and internal register map of the wireless LAN MAC core.
// Functional notes
// - Fetch address comes from program counter, instruction literal or call stack.
// - ALU reads shared memory, scratchpad, hardware registers or literals; writes the first three.
// - Branches test hardware condition lines directly, or the ALU zero result.
// - Engines are steered by internal hardware registers written over the internal bus.
// - Sequencer selects cipher and loads the key from the on-chip key table.
// - Cipher encrypts and seals transmit bytes, decrypts and checks receive bytes in line.
// - Transmit queue for the next frame is picked using channel access information.
// - A scheduled frame starts towards the PHY only on its trigger: the queue's backoff grant, or the SIFS or RIFS timer pulse.
// - Aggregated frames get a delimiter header and padding to a word boundary.
// - Receive frames are marked accepted or rejected by address, BSSID and frame type filters.
// - Received aggregates are detected, delimiters parsed, and split into single MPDUs.
// - Interframe timers start when the PHY reports end of channel activity and the NAV is zero.
// - Response and burst frames start on the SIFS or RIFS timer outputs.
// - Each access category has a backoff engine sampled once per slot.
// - A backoff counter reaching zero notifies the transmit engine.
// - Simultaneous zero counters are resolved by a sequencer-configured policy.
// - Power save stops the MAC clock; a slow sleep timer restores it.
// - After waking the sequencer advances the TSF by the slept duration.
// - TSF can adopt received beacon timestamps and keeps the beacon target time.
// - Trigger pulses fire when the TSF reaches programmed offsets.
// - NAV is updated from received duration fields and feeds virtual carrier sense.
// - PHY programming port is driven by either the host or the sequencer.
// - Backoff decrements only while the channel is clear, holds while busy.
`ifndef WM_PARAMS_SVH
`define WM_PARAMS_SVH
`define WM_CLK_NS 5
`define WM_US_NS 1000
`define WM_US_CYC (`WM_US_NS / `WM_CLK_NS)
`define WM_RIFS_NS 2000
`define WM_RIFS_CYC (`WM_RIFS_NS / `WM_CLK_NS)
`define WM_SIFS_NS 16000
`define WM_SIFS_CYC (`WM_SIFS_NS / `WM_CLK_NS)
`define WM_SLOT_NS 9000
`define WM_SLOT_CYC (`WM_SLOT_NS / `WM_CLK_NS)
`define WM_SLOW_NS 30518
`define WM_SLOW_CYC (`WM_SLOW_NS / `WM_CLK_NS)
`define WM_DLM_SIG 8'h4E
`define WM_STATE_RST '0
`define WM_IW_NAV 6'h00
`define WM_IW_TSFCMD 6'h01
`define WM_IW_TSFADD 6'h02
`define WM_IW_TBTT 6'h03
`define WM_IW_TRIG 6'h04
`define WM_IW_BO0 6'h05
`define WM_IW_POLICY 6'h09
`define WM_IW_SLEEP 6'h0A
`define WM_IW_RA 6'h0B
`define WM_IW_BSS 6'h0C
`define WM_IW_TYPES 6'h0D
`define WM_IW_CIPHER 6'h0E
`define WM_IW_KEY 6'h0F
`define WM_IW_TXQ 6'h10
`define WM_IW_TXLEN 6'h11
`define WM_IW_PHYA 6'h12
`define WM_IW_PHYD 6'h13
`define WM_IR_TSFLO 6'h20
`define WM_IR_TSFHI 6'h21
`define WM_IR_NAV 6'h22
`define WM_IR_SLEPT 6'h23
`define WM_IR_STAT 6'h24
`define WM_IR_DUR 6'h25
`define WM_IR_TSLO 6'h26
`define WM_IR_TSHI 6'h27
`define WM_IR_RXINFO 6'h28
`endif

/* File: verilog/wm_pkg.sv */
// Types shared by the wireless LAN MAC core.
package wm_pkg;
	typedef enum logic [3:0] {
		OP_NOP, OP_MOV, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
		OP_JMP, OP_JC, OP_JZ, OP_JNZ, OP_CALL, OP_RET
	} wm_op_e;
	typedef enum logic [1:0] {SEL_SHM, SEL_SCR, SEL_IHR, SEL_LIT} wm_sel_e;
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_DELIM, TX_DATA, TX_MIC, TX_PAD} wm_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_DELIM, RX_BODY, RX_SKIP} wm_rx_e;
	typedef struct packed {
		logic [63:0][31:0] ucode;
		logic [15:0][15:0] shared_memory_bus;
		logic [7:0][15:0]  scr;
		logic [3:0][5:0]   stk;
		logic [1:0]        sp;
		logic [5:0]        pc;
		logic              zf;
		logic [4:0]        evt;
		logic [15:0]       shmRd;
		logic [31:0]       tsf;
		logic [15:0]       tbtt;
		logic [15:0]       trigOfs;
		logic [7:0]        usCnt;
		logic              tbttP;
		logic              trigP;
		logic [15:0]       nav;
		logic              idleQ;
		logic              ifsRun;
		logic              ifsDone;
		logic              rifsP;
		logic              sifsP;
		logic [11:0]       ifsCnt;
		logic [11:0]       slotCnt;
		logic [3:0][15:0]  bo;
		logic [3:0]        boArm;
		logic [3:0]        grant;
		logic              policy;
		logic              asleep;
		logic [15:0]       sleepCnt;
		logic [15:0]       slept;
		logic [15:0]       slowCnt;
		logic [3:0][15:0]  key;
		logic [1:0]        keyIdx;
		logic [1:0]        alg;
		logic [7:0]        phyAddr;
		logic              progWr;
		logic [7:0]        progAddr;
		logic [15:0]       progData;
		wm_tx_e            txSt;
		logic [1:0]        txQ;
		logic              aggr;
		logic [1:0]        txMode;
		logic [11:0]       txLen;
		logic [11:0]       txIdx;
		logic [7:0]        txMic;
		logic [1:0]        txAlign;
		logic [7:0]        txOutD;
		logic              txOutV;
		logic              txOutL;
		logic              txDoneP;
		wm_rx_e            rxSt;
		logic [11:0]       rxLen;
		logic [11:0]       rxIdx;
		logic [1:0]        rxAlign;
		logic [1:0]        dlmCnt;
		logic [7:0]        dlm0;
		logic [7:0]        rxAcc;
		logic [1:0]        rxType;
		logic [15:0]       rxDur;
		logic [15:0]       rxRa;
		logic [15:0]       rxBss;
		logic [31:0]       rxTs;
		logic [15:0]       raF;
		logic [15:0]       bssF;
		logic [3:0]        typeMask;
		logic [7:0]        rxOutD;
		logic              rxOutV;
		logic              rxOutEnd;
		logic              rxAccept;
		logic              rxMicOk;
	} wm_state_s;
endpackage

/* File: verilog/wm_mac_core.sv */
// Wireless LAN MAC core: sequencer, timers, backoff, cipher, transmit and receive engines.
`timescale 1ns/10ps
`include "wm_params.svh"
module wm_mac_core
	import wm_pkg::*;
#(
	parameter logic [15:0] SLOW_DIV = 16'(`WM_SLOW_CYC)
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        seqEnable,
	input  wire logic        ucodeWr,
	input  wire logic [5:0]  ucodeAddr,
	input  wire logic [31:0] ucodeData,
	input  wire logic        shmHostWr,
	input  wire logic [3:0]  shmHostAddr,
	input  wire logic [15:0] shmHostWdata,
	output logic      [15:0] shmHostRdata,
	input  wire logic        phyCca,
	input  wire logic        phyRxValid,
	input  wire logic [7:0]  phyRxData,
	input  wire logic        phyRxAmpdu,
	input  wire logic        phyRxEnd,
	output logic      [7:0]  rxOutData,
	output logic             rxOutValid,
	output logic             rxOutEnd,
	output logic             rxOutAccept,
	output logic             rxOutMicOk,
	input  wire logic [3:0]  txQueueAvail,
	output logic      [1:0]  txDmaQueue,
	input  wire logic [7:0]  txDmaData,
	input  wire logic        txDmaValid,
	output logic             txDmaReady,
	output logic      [7:0]  phyTxData,
	output logic             phyTxValid,
	output logic             phyTxLast,
	input  wire logic        phyTxReady,
	input  wire logic        hostPhyOwn,
	input  wire logic        hostPhyWr,
	input  wire logic [7:0]  hostPhyAddr,
	input  wire logic [15:0] hostPhyData,
	output logic             phyProgWr,
	output logic      [7:0]  phyProgAddr,
	output logic      [15:0] phyProgData,
	output logic             macClkEn,
	output logic             tbttPulse,
	output logic             tsfTrigPulse,
	output logic      [3:0]  boGrant,
	output logic             navBusy
);
	wm_state_s s_q;
	wm_state_s s_d;
	logic [31:0] ins;
	wm_op_e      op;
	wm_sel_e     dSel;
	wm_sel_e     sSel;
	logic [5:0]  dAdr;
	logic [5:0]  sAdr;
	logic [15:0] lit;
	logic [15:0] opA;
	logic [15:0] opB;
	logic [15:0] res;
	logic [7:0]  cond;
	logic        step;
	logic        wrEn;
	logic        ihrWr;
	logic        run;
	logic        busy;
	logic        usTick;
	logic        slowTick;
	logic        slotTick;
	logic        wake;
	logic [3:0]  zeroV;
	logic [3:0]  gSel;
	logic        txTrig;
	logic        txHave;
	logic        txEnd;
	logic [7:0]  txB;
	logic        ld;
	logic [7:0]  rxD;
	logic        fin;
	wm_rx_e      cur;

	// Keystream byte for a stream position; both directions use the same XOR.
	function automatic logic [7:0] wmKs(input logic [15:0] k, input logic [1:0] a,
		input logic [11:0] i);
		logic [7:0] b;
		b = i[0] ? k[15:8] : k[7:0];
		if (a == 2'h0) begin
			b = 8'h00;
		end else if (a == 2'h2) begin
			b = b ^ i[7:0];
		end
		return b;
	endfunction

	function automatic logic [15:0] wmIhrRd(input wm_state_s st, input logic [5:0] a,
		input logic [3:0] qa);
		case (a)
			`WM_IR_TSFLO: return st.tsf[15:0];
			`WM_IR_TSFHI: return st.tsf[31:16];
			`WM_IR_NAV: return st.nav;
			`WM_IR_SLEPT: return st.slept;
			`WM_IR_STAT: return {5'h00, st.txSt, qa, st.grant};
			`WM_IR_DUR: return st.rxDur;
			`WM_IR_TSLO: return st.rxTs[15:0];
			`WM_IR_TSHI: return st.rxTs[31:16];
			`WM_IR_RXINFO: return {12'h000, st.rxAccept, st.rxMicOk, st.rxType};
			default: return 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] wmOp(input wm_state_s st, input wm_sel_e sel,
		input logic [5:0] a, input logic [15:0] l, input logic [3:0] qa);
		case (sel)
			SEL_SHM: return st.shared_memory_bus[a[3:0]];
			SEL_SCR: return st.scr[a[2:0]];
			SEL_IHR: return wmIhrRd(st, a, qa);
			default: return l;
		endcase
	endfunction

	always_comb begin
		s_d = s_q;
		ins = s_q.ucode[s_q.pc];
		op = wm_op_e'(ins[31:28]);
		dSel = wm_sel_e'(ins[27:26]);
		dAdr = ins[25:20];
		sSel = wm_sel_e'(ins[19:18]);
		sAdr = ins[17:12];
		lit = {4'h0, ins[11:0]};
		run = !s_q.asleep;
		step = run && seqEnable;
		busy = phyCca || (s_q.nav != 16'h0000);
		usTick = run && (s_q.usCnt == 8'(`WM_US_CYC - 1));
		slowTick = (s_q.slowCnt == SLOW_DIV - 16'h0001);
		slotTick = run && !busy && s_q.ifsDone && (s_q.slotCnt == 12'(`WM_SLOT_CYC - 1));
		cond = {s_q.evt, |s_q.grant, s_q.ifsDone, s_q.nav != 16'h0000};
		opA = wmOp(s_q, dSel, dAdr, lit, txQueueAvail);
		opB = wmOp(s_q, sSel, sAdr, lit, txQueueAvail);
		case (op)
			OP_ADD: res = opA + opB;
			OP_SUB: res = opA - opB;
			OP_AND: res = opA & opB;
			OP_OR: res = opA | opB;
			OP_XOR: res = opA ^ opB;
			default: res = opB;
		endcase
		wrEn = step && (op >= OP_MOV) && (op <= OP_XOR) && (dSel != SEL_LIT);
		ihrWr = wrEn && (dSel == SEL_IHR);
		wake = 1'b0;
		zeroV = 4'h0;
		gSel = 4'h0;
		txTrig = 1'b0;
		txHave = 1'b0;
		txEnd = 1'b0;
		txB = 8'h00;
		ld = !s_q.txOutV || phyTxReady;
		rxD = phyRxData ^ wmKs(s_q.key[s_q.keyIdx], s_q.alg, s_q.rxIdx);
		fin = 1'b0;
		cur = s_q.rxSt;
		s_d.progWr = 1'b0;
		s_d.txDoneP = 1'b0;

		// Sequencer fetch and branch.
		if (step) begin
			s_d.pc = s_q.pc + 6'h01;
			case (op)
				OP_JMP: s_d.pc = lit[5:0];
				OP_JC: begin
					if (cond[sAdr[2:0]]) begin
						s_d.pc = lit[5:0];
					end
					if (sAdr[2:0] >= 3'h3) begin
						s_d.evt[sAdr[2:0] - 3'h3] = 1'b0;
					end
				end
				OP_JZ: s_d.pc = s_q.zf ? lit[5:0] : s_d.pc;
				OP_JNZ: s_d.pc = s_q.zf ? s_d.pc : lit[5:0];
				OP_CALL: begin
					s_d.stk[s_q.sp] = s_q.pc + 6'h01;
					s_d.sp = s_q.sp + 2'h1;
					s_d.pc = lit[5:0];
				end
				OP_RET: begin
					s_d.sp = s_q.sp - 2'h1;
					s_d.pc = s_q.stk[s_q.sp - 2'h1];
				end
				default: ;
			endcase
		end
		if (wrEn) begin
			s_d.zf = (res == 16'h0000);
			if (dSel == SEL_SHM) begin
				s_d.shared_memory_bus[dAdr[3:0]] = res;
			end
			if (dSel == SEL_SCR) begin
				s_d.scr[dAdr[2:0]] = res;
			end
		end

		// Slow clock divider and sleep timer keep running while the MAC is stopped.
		s_d.slowCnt = slowTick ? 16'h0000 : s_q.slowCnt + 16'h0001;
		if (s_q.asleep && slowTick) begin
			s_d.slept = s_q.slept + 16'h0001;
			s_d.sleepCnt = s_q.sleepCnt - 16'h0001;
			if (s_q.sleepCnt <= 16'h0001) begin
				s_d.asleep = 1'b0;
				wake = 1'b1;
			end
		end

		// Microsecond tick, TSF, NAV and trigger comparators.
		s_d.tbttP = 1'b0;
		s_d.trigP = 1'b0;
		if (run) begin
			s_d.usCnt = usTick ? 8'h00 : s_q.usCnt + 8'h01;
		end
		if (usTick) begin
			s_d.tsf = s_q.tsf + 32'h0000_0001;
			s_d.tbttP = (s_q.tsf[15:0] == s_q.tbtt);
			s_d.trigP = (s_q.tsf[15:0] == s_q.trigOfs);
			if (s_q.nav != 16'h0000) begin
				s_d.nav = s_q.nav - 16'h0001;
			end
		end

		// Interframe timers restart on each idle edge of the medium.
		s_d.rifsP = 1'b0;
		s_d.sifsP = 1'b0;
		if (run) begin
			s_d.idleQ = !busy;
			if (busy) begin
				s_d.ifsRun = 1'b0;
				s_d.ifsDone = 1'b0;
				s_d.slotCnt = 12'h000;
			end else if (!s_q.idleQ) begin
				s_d.ifsRun = 1'b1;
				s_d.ifsCnt = 12'h000;
			end else if (s_q.ifsRun) begin
				s_d.ifsCnt = s_q.ifsCnt + 12'h001;
				s_d.rifsP = (s_q.ifsCnt == 12'(`WM_RIFS_CYC - 1));
				if (s_q.ifsCnt == 12'(`WM_SIFS_CYC - 1)) begin
					s_d.sifsP = 1'b1;
					s_d.ifsRun = 1'b0;
					s_d.ifsDone = 1'b1;
				end
			end else if (s_q.ifsDone) begin
				s_d.slotCnt = slotTick ? 12'h000 : s_q.slotCnt + 12'h001;
			end
		end

		// Per-category backoff; slot ticks only occur on a clear medium.
		for (int i = 0; i < 4; i++) begin
			if (slotTick && s_q.bo[i] != 16'h0000) begin
				s_d.bo[i] = s_q.bo[i] - 16'h0001;
			end
			if (slotTick && s_q.boArm[i] && s_q.bo[i] <= 16'h0001) begin
				zeroV[i] = 1'b1;
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (s_q.policy && zeroV[i]) begin
				gSel = 4'h1 << i;
			end
			if (!s_q.policy && zeroV[3 - i]) begin
				gSel = 4'h1 << (3 - i);
			end
		end
		if (s_q.grant == 4'h0) begin
			s_d.grant = gSel;
			s_d.boArm = s_q.boArm & ~gSel;
		end

		// Transmit engine.
		case (s_q.txMode)
			2'h1: txTrig = s_q.sifsP;
			2'h2: txTrig = s_q.rifsP;
			default: txTrig = s_q.grant[s_q.txQ];
		endcase
		case (s_q.txSt)
			TX_WAIT: begin
				if (run && txTrig) begin
					s_d.txSt = s_q.aggr ? TX_DELIM : (s_q.txLen == 12'h000 ? TX_MIC : TX_DATA);
					s_d.txIdx = 12'h000;
					s_d.grant[s_q.txQ] = 1'b0;
				end
			end
			TX_DELIM: begin
				txHave = 1'b1;
				case (s_q.txIdx[1:0])
					2'h0: txB = 8'(s_q.txLen + 12'h001);
					2'h1: txB = {4'h0, 4'((s_q.txLen + 12'h001) >> 8)};
					2'h2: txB = ~(8'(s_q.txLen + 12'h001));
					default: txB = `WM_DLM_SIG;
				endcase
				if (run && ld) begin
					s_d.txIdx = (s_q.txIdx[1:0] == 2'h3) ? 12'h000 : s_q.txIdx + 12'h001;
					if (s_q.txIdx[1:0] == 2'h3) begin
						s_d.txSt = (s_q.txLen == 12'h000) ? TX_MIC : TX_DATA;
					end
				end
			end
			TX_DATA: begin
				txHave = txDmaValid;
				txB = txDmaData ^ wmKs(s_q.key[s_q.keyIdx], s_q.alg, s_q.txIdx);
				if (run && ld && txDmaValid) begin
					s_d.txMic = s_q.txMic ^ txDmaData;
					s_d.txIdx = s_q.txIdx + 12'h001;
					s_d.txAlign = s_q.txAlign + 2'h1;
					if (s_q.txIdx == s_q.txLen - 12'h001) begin
						s_d.txSt = TX_MIC;
					end
				end
			end
			TX_MIC: begin
				txHave = 1'b1;
				txB = s_q.txMic ^ wmKs(s_q.key[s_q.keyIdx], s_q.alg, s_q.txIdx);
				txEnd = !(s_q.aggr && s_q.txAlign != 2'h3);
				if (run && ld) begin
					s_d.txAlign = s_q.txAlign + 2'h1;
					s_d.txSt = txEnd ? TX_IDLE : TX_PAD;
				end
			end
			TX_PAD: begin
				txHave = 1'b1;
				txEnd = (s_q.txAlign == 2'h3);
				if (run && ld) begin
					s_d.txAlign = s_q.txAlign + 2'h1;
					s_d.txSt = txEnd ? TX_IDLE : TX_PAD;
				end
			end
			default: ;
		endcase
		if (run && ld) begin
			s_d.txOutV = txHave;
			s_d.txOutD = txB;
			s_d.txOutL = txEnd;
			s_d.txDoneP = txHave && txEnd;
		end

		// Receive engine with aggregate splitting and address filters.
		s_d.rxOutV = 1'b0;
		s_d.rxOutEnd = 1'b0;
		if (run && (phyRxValid || phyRxEnd)) begin
			if (s_q.rxSt == RX_IDLE) begin
				cur = phyRxAmpdu ? RX_DELIM : RX_BODY;
				s_d.rxIdx = 12'h000;
				s_d.rxAcc = 8'h00;
				s_d.rxAlign = 2'h0;
				s_d.dlmCnt = 2'h0;
				s_d.rxLen = 12'hFFF;
			end
			s_d.rxSt = cur;
		end
		if (run && phyRxValid) begin
			s_d.rxAlign = s_d.rxAlign + 2'h1;
			case (cur)
				RX_DELIM: begin
					s_d.dlmCnt = s_d.dlmCnt + 2'h1;
					if (s_d.dlmCnt == 2'h1) begin
						s_d.dlm0 = phyRxData;
					end
					if (s_d.dlmCnt == 2'h2) begin
						s_d.rxLen = {phyRxData[3:0], s_d.dlm0};
					end
					if (s_d.dlmCnt == 2'h0) begin
						s_d.rxSt = (s_d.rxLen == 12'h000) ? RX_DELIM : RX_BODY;
						s_d.rxIdx = 12'h000;
						s_d.rxAcc = 8'h00;
					end
				end
				RX_BODY: begin
					s_d.rxOutV = 1'b1;
					s_d.rxOutD = rxD;
					s_d.rxAcc = s_d.rxAcc ^ rxD;
					case (s_d.rxIdx)
						12'd0: s_d.rxType = rxD[3:2];
						12'd2: s_d.rxDur[7:0] = rxD;
						12'd3: s_d.rxDur[15:8] = rxD;
						12'd4: s_d.rxRa[7:0] = rxD;
						12'd5: s_d.rxRa[15:8] = rxD;
						12'd16: s_d.rxBss[7:0] = rxD;
						12'd17: s_d.rxBss[15:8] = rxD;
						12'd24: s_d.rxTs[7:0] = rxD;
						12'd25: s_d.rxTs[15:8] = rxD;
						12'd26: s_d.rxTs[23:16] = rxD;
						12'd27: s_d.rxTs[31:24] = rxD;
						default: ;
					endcase
					s_d.rxIdx = s_d.rxIdx + 12'h001;
					if (s_d.rxIdx == s_d.rxLen) begin
						fin = 1'b1;
						s_d.dlmCnt = 2'h0;
						s_d.rxSt = (s_d.rxAlign == 2'h0) ? RX_DELIM : RX_SKIP;
					end
				end
				RX_SKIP: begin
					if (s_d.rxAlign == 2'h0) begin
						s_d.rxSt = RX_DELIM;
					end
				end
				default: ;
			endcase
		end
		if (run && phyRxEnd) begin
			fin = fin || (s_d.rxSt == RX_BODY);
			s_d.rxSt = RX_IDLE;
		end
		if (fin) begin
			s_d.rxOutEnd = 1'b1;
			s_d.rxMicOk = (s_d.rxAcc == 8'h00);
			s_d.rxAccept = (s_d.rxRa == s_q.raF) && (s_d.rxBss == s_q.bssF)
				&& s_q.typeMask[s_d.rxType];
		end

		// Internal hardware register writes.
		if (ihrWr) begin
			case (dAdr)
				`WM_IW_NAV: begin
					if (res[0] && s_q.rxDur > s_d.nav) begin
						s_d.nav = s_q.rxDur;
					end
					if (res[1]) begin
						s_d.nav = 16'h0000;
					end
				end
				`WM_IW_TSFCMD: s_d.tsf = res[0] ? s_q.rxTs : s_d.tsf;
				`WM_IW_TSFADD: s_d.tsf = s_d.tsf + {16'h0000, res};
				`WM_IW_TBTT: s_d.tbtt = res;
				`WM_IW_TRIG: s_d.trigOfs = res;
				`WM_IW_POLICY: s_d.policy = res[0];
				`WM_IW_SLEEP: begin
					s_d.sleepCnt = res;
					s_d.asleep = (res != 16'h0000);
					s_d.slept = 16'h0000;
				end
				`WM_IW_RA: s_d.raF = res;
				`WM_IW_BSS: s_d.bssF = res;
				`WM_IW_TYPES: s_d.typeMask = res[3:0];
				`WM_IW_CIPHER: begin
					s_d.keyIdx = res[1:0];
					s_d.alg = res[3:2];
				end
				`WM_IW_KEY: s_d.key[s_q.keyIdx] = res;
				`WM_IW_TXQ: begin
					s_d.txQ = res[1:0];
					s_d.aggr = res[2];
					s_d.txMode = res[4:3];
				end
				`WM_IW_TXLEN: begin
					if (s_q.txSt == TX_IDLE) begin
						s_d.txLen = res[11:0];
						s_d.txSt = TX_WAIT;
						s_d.txMic = 8'h00;
						s_d.txAlign = 2'h0;
					end
				end
				`WM_IW_PHYA: s_d.phyAddr = res[7:0];
				default: begin
					if (dAdr >= `WM_IW_BO0 && dAdr < `WM_IW_POLICY) begin
						s_d.bo[2'(dAdr - `WM_IW_BO0)] = res;
						s_d.boArm[2'(dAdr - `WM_IW_BO0)] = 1'b1;
					end
				end
			endcase
		end

		// PHY programming port, shared between host and sequencer.
		if (hostPhyOwn) begin
			s_d.progWr = hostPhyWr;
			s_d.progAddr = hostPhyWr ? hostPhyAddr : s_q.progAddr;
			s_d.progData = hostPhyWr ? hostPhyData : s_q.progData;
		end else if (ihrWr && dAdr == `WM_IW_PHYD) begin
			s_d.progWr = 1'b1;
			s_d.progAddr = s_q.phyAddr;
			s_d.progData = res;
		end

		// Hardware events are set after the sequencer clear so that a set wins.
		s_d.evt = s_d.evt | {s_d.txDoneP, s_d.rxOutEnd, s_d.trigP, s_d.tbttP, wake};

		// Host access to microcode and shared memory.
		if (ucodeWr) begin
			s_d.ucode[ucodeAddr] = ucodeData;
		end
		if (shmHostWr) begin
			s_d.shared_memory_bus[shmHostAddr] = shmHostWdata;
		end
		s_d.shmRd = s_q.shared_memory_bus[shmHostAddr];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_q <= `WM_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign shmHostRdata = s_q.shmRd;
	assign rxOutData = s_q.rxOutD;
	assign rxOutValid = s_q.rxOutV;
	assign rxOutEnd = s_q.rxOutEnd;
	assign rxOutAccept = s_q.rxAccept;
	assign rxOutMicOk = s_q.rxMicOk;
	assign txDmaQueue = s_q.txQ;
	assign txDmaReady = run && (s_q.txSt == TX_DATA) && ld;
	assign phyTxData = s_q.txOutD;
	assign phyTxValid = s_q.txOutV;
	assign phyTxLast = s_q.txOutL;
	assign phyProgWr = s_q.progWr;
	assign phyProgAddr = s_q.progAddr;
	assign phyProgData = s_q.progData;
	assign macClkEn = !s_q.asleep;
	assign tbttPulse = s_q.tbttP;
	assign tsfTrigPulse = s_q.trigP;
	assign boGrant = s_q.grant;
	assign navBusy = (s_q.nav != 16'h0000);
endmodule

/* File: verification/wm_mac_core_monitor.sv */
// Port checker for the MAC core.
`timescale 1ns/10ps
module wm_mac_core_monitor (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        macClkEn,
	input wire logic [7:0]  phyTxData,
	input wire logic        phyTxValid,
	input wire logic        phyTxLast,
	input wire logic        phyTxReady,
	input wire logic        hostPhyOwn,
	input wire logic        hostPhyWr,
	input wire logic [7:0]  hostPhyAddr,
	input wire logic [15:0] hostPhyData,
	input wire logic        phyProgWr,
	input wire logic [7:0]  phyProgAddr,
	input wire logic [15:0] phyProgData,
	input wire logic [3:0]  boGrant,
	input wire logic        phyRxValid,
	input wire logic        rxOutValid,
	input wire logic        tbttPulse,
	input wire logic        tsfTrigPulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_tx_stall_hold: assert property (phyTxValid && !phyTxReady |=>
		phyTxValid && $stable(phyTxData) && $stable(phyTxLast)) else $error("tx byte lost");
	chk_tx_last_valid: assert property (phyTxLast |-> phyTxValid)
		else $error("tx last without valid");
	chk_prog_host_path: assert property (hostPhyOwn && hostPhyWr && macClkEn |=> phyProgWr
		&& phyProgAddr == $past(hostPhyAddr) && phyProgData == $past(hostPhyData))
		else $error("host phy write not forwarded");
	chk_grant_one_hot: assert property ($onehot0(boGrant)) else $error("two grants");
	chk_rx_byte_cause: assert property (rxOutValid |-> $past(phyRxValid))
		else $error("rx byte without input");
	chk_tbtt_pulse_once: assert property (tbttPulse |=> !tbttPulse)
		else $error("tbtt pulse too long");
	chk_trig_pulse_once: assert property (tsfTrigPulse |=> !tsfTrigPulse)
		else $error("trigger pulse too long");
	chk_sleep_frozen: assert property (!macClkEn && !$past(macClkEn) |->
		!rxOutValid && !tbttPulse) else $error("activity while asleep");
endmodule
bind wm_mac_core wm_mac_core_monitor mon (.*);

/* File: verification/wm_phy_model.sv */
// Behavioural PHY datapath: stalls transmit every other cycle and sends receive bursts.
`timescale 1ns/10ps
module wm_phy_model (
	input wire logic       ref_clk,
	input wire logic [7:0] phyTxData,
	input wire logic       phyTxValid,
	input wire logic       phyTxLast,
	output logic           phyTxReady,
	output logic           phyRxValid,
	output logic [7:0]     phyRxData,
	output logic           phyRxAmpdu,
	output logic           phyRxEnd
);
	logic [8:0] txSeen[$];
	initial begin
		phyTxReady = 1'h0;
		phyRxValid = 1'h0;
		phyRxData  = 8'h00;
		phyRxAmpdu = 1'h0;
		phyRxEnd   = 1'h0;
	end
	always @(posedge ref_clk) begin
		if (phyTxValid && phyTxReady)
			txSeen.push_back({phyTxLast, phyTxData});
		phyTxReady <= #1 ~phyTxReady;
	end
	// Released data shows its inverse, never a stale byte.
	task automatic sendRx(input logic [7:0] b[$], input logic agg);
		foreach (b[i]) begin
			@(posedge ref_clk);
			#1;
			phyRxValid = 1'h1;
			phyRxData  = b[i];
			phyRxAmpdu = agg;
		end
		@(posedge ref_clk);
		#1;
		phyRxValid = 1'h0;
		phyRxData  = ~phyRxData;
		phyRxEnd   = 1'h1;
		@(posedge ref_clk);
		#1;
		phyRxEnd = 1'h0;
	endtask
endmodule

/* File: verification/wm_mac_core_tb_top.sv */
// Self-checking bench for the MAC core against a behavioural PHY.
`timescale 1ns/10ps
`include "wm_params.svh"
module wm_mac_core_tb_top;
	logic        ref_clk = 1'h0, sys_rst = 1'h1, seqEnable = 1'h0, ucodeWr = 1'h0;
	logic        shmHostWr = 1'h0, phyCca = 1'h1, txDmaValid = 1'h0;
	logic        hostPhyOwn = 1'h0, hostPhyWr = 1'h0;
	logic [3:0]  shmHostAddr = 4'h0, txQueueAvail = 4'h2;
	logic [5:0]  ucodeAddr = 6'h00;
	logic [31:0] ucodeData = 32'h0;
	logic [15:0] shmHostWdata = 16'h0, hostPhyData = 16'h0, shmHostRdata, phyProgData;
	logic [7:0]  hostPhyAddr = 8'h00, txDmaData = 8'hA5;
	logic [7:0]  rxOutData, phyTxData, phyProgAddr, phyRxData;
	logic [3:0]  boGrant;
	logic [1:0]  txDmaQueue;
	logic        rxOutValid, rxOutEnd, rxOutAccept, rxOutMicOk, txDmaReady, phyTxValid;
	logic        phyTxLast, phyProgWr, macClkEn, tbttPulse, tsfTrigPulse, navBusy;
	logic        phyTxReady, phyRxValid, phyRxAmpdu, phyRxEnd, lastMic;
	int          err_count = 0, n_compared = 0, cyc = 0, nOut = 0, nEnd = 0, n;
	wm_mac_core #(.SLOW_DIV(16'h0004)) uut (.*);
	wm_phy_model phy (.*);
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		nOut += int'(rxOutValid === 1'h1);
		if (rxOutEnd === 1'h1) begin
			nEnd++;
			lastMic = rxOutMicOk;
		end
		if (txDmaValid && txDmaReady)
			txDmaData <= txDmaData + 8'h01;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end
	task automatic check(input string what, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic waitLvl(ref logic sig, input logic v, input int lim);
		n = 0;
		while (sig !== v && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	function automatic logic [31:0] ins(input logic [3:0] op, input logic [1:0] ds,
		input logic [5:0] da, input logic [1:0] ss, input logic [5:0] sa, input logic [11:0] l);
		return {op, ds, da, ss, sa, l};
	endfunction
	// Reset clears microcode too, so every program is loaded after a fresh reset.
	task automatic boot(input logic [31:0] prog[$]);
		seqEnable = 1'h0;
		sys_rst   = 1'h1;
		tick(6);
		sys_rst = 1'h0;
		foreach (prog[i]) begin
			ucodeWr   = 1'h1;
			ucodeAddr = 6'(i);
			ucodeData = prog[i];
			tick(1);
		end
		ucodeWr = 1'h0;
	endtask
	task automatic testHost;
		shmHostWr    = 1'h1;
		shmHostAddr  = 4'h9;
		shmHostWdata = 16'hC35A;
		tick(1);
		shmHostWr = 1'h0;
		tick(1);
		check("shm read", shmHostRdata, 32'h0000C35A);
		hostPhyOwn  = 1'h1;
		hostPhyWr   = 1'h1;
		hostPhyAddr = 8'h3C;
		hostPhyData = 16'hBEEF;
		tick(1);
		hostPhyWr = 1'h0;
		check("phy prog", {phyProgWr, phyProgAddr, phyProgData}, 32'h013CBEEF);
		$display("host test done");
	endtask
	task automatic rxCase(input logic [7:0] b[$], input logic agg, input int outs, ends, mic);
		nOut = 0;
		nEnd = 0;
		phy.sendRx(b, agg);
		tick(2);
		check("rx bytes", nOut, outs);
		check("rx ends", nEnd, ends);
		check("rx mic", lastMic, mic);
	endtask
	task automatic testRx;
		rxCase('{8'h11, 8'h22, 8'h33, 8'h00}, 1'h0, 4, 1, 1);
		rxCase('{8'h11, 8'h22, 8'h33, 8'h01}, 1'h0, 4, 1, 0);
		rxCase('{8'h03, 8'h00, 8'hFC, 8'h4E, 8'h05, 8'h0A, 8'h0F, 8'h00, 8'h00, 8'h00,
			8'hFF, 8'h4E, 8'h03, 8'h00, 8'hFC, 8'h4E, 8'h05, 8'h0A, 8'h0F, 8'h00}, 1'h1, 6, 2, 1);
		check("rx accept", rxOutAccept, 1'h0);
		$display("receive test done");
	endtask
	task automatic testSleep;
		boot('{ins(4'h1, 2'h2, `WM_IW_SLEEP, 2'h3, 6'h00, 12'h002),
			ins(4'h1, 2'h1, 6'h00, 2'h2, `WM_IR_TSFLO, 12'h000),
			ins(4'h2, 2'h1, 6'h00, 2'h3, 6'h00, 12'h004),
			ins(4'h1, 2'h2, `WM_IW_TBTT, 2'h1, 6'h00, 12'h000),
			ins(4'h1, 2'h2, `WM_IW_TRIG, 2'h1, 6'h00, 12'h000),
			ins(4'h7, 2'h0, 6'h00, 2'h0, 6'h00, 12'h005)});
		seqEnable = 1'h1;
		waitLvl(macClkEn, 1'h0, 20);
		check("sleep entry", n < 20, 1);
		waitLvl(macClkEn, 1'h1, 40);
		check("sleep length", n > 3 && n < 16, 1);
		waitLvl(tbttPulse, 1'h1, 1000);
		check("tbtt time", n > 980 && n < 1000, 1);
		check("trigger", tsfTrigPulse, 1'h1);
		$display("sleep test done");
	endtask
	task automatic testTx;
		boot('{ins(4'h1, 2'h2, `WM_IW_TXQ, 2'h3, 6'h00, 12'h001),
			ins(4'h1, 2'h2, `WM_IW_BO0 + 6'h01, 2'h3, 6'h00, 12'h002),
			ins(4'h1, 2'h2, `WM_IW_TXLEN, 2'h3, 6'h00, 12'h002),
			ins(4'h7, 2'h0, 6'h00, 2'h0, 6'h00, 12'h003)});
		seqEnable  = 1'h1;
		txDmaValid = 1'h1;
		tick(3000);
		check("grant while busy", boGrant, 4'h0);
		phyCca = 1'h0;
		n = 0;
		while (boGrant === 4'h0 && n < 9000) begin
			tick(1);
			n++;
		end
		check("grant", boGrant, 4'h2);
		check("backoff slots", n > `WM_SIFS_CYC + `WM_SLOT_CYC, 1);
		check("early tx", phy.txSeen.size(), 0);
		check("queue", txDmaQueue, 2'h1);
		check("nav", navBusy, 1'h0);
		n = 0;
		while (phy.txSeen.size() < 3 && n < 200) begin
			tick(1);
			n++;
		end
		check("tx byte 0", phy.txSeen[0], 9'h0A5);
		check("tx byte 1", phy.txSeen[1], 9'h0A6);
		check("tx mic", phy.txSeen[2], 9'h103);
		$display("transmit test done");
	endtask
	initial begin
		boot('{32'h0});
		testHost();
		testRx();
		testSleep();
		testTx();
		summarize();
	end
endmodule
